// ---- alu_datapath.v ----
// Arithmetic and logic datapath with status flags and I/O bit access
`timescale 1ns/100ps
`include "alu_regs.vh"
module alu_datapath
(
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Operation request
	input  wire       op_valid,
	input  wire [3:0] op_code,
	input  wire [7:0] op_dst,
	input  wire [7:0] op_hi,
	input  wire [7:0] op_src,
	input  wire [7:0] op_const,
	input  wire [5:0] op_io_addr,
	input  wire [2:0] op_io_bit,
	// Operation result
	output reg        res_valid_q,
	output reg  [7:0] res_lo_q,
	output reg  [7:0] res_hi_q,
	output reg        res_word_q,
	output reg        op_err_q,
	output reg        busy_q,
	output reg  [7:0] sreg_q,
	// Register port
	input  wire [5:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output wire [7:0] reg_rdata
);

localparam SEL_ZERO = 2'd0;
localparam SEL_MEM  = 2'd1;
localparam SEL_SREG = 2'd2;

reg  [1:0] cnt_q;
reg  [3:0] op_q;
reg  [7:0] lo_q;
reg  [7:0] hi_q;
reg        cy_q;
reg  [4:0] io_addr_q;
reg  [2:0] io_bit_q;
reg  [1:0] rsel_q;
reg  [7:0] sreg_rd_q;
reg  [7:0] r_d;
reg  [7:0] f_d;
reg  [7:0] b_op;
reg        cin;
reg  [8:0] sum9;
reg  [8:0] dif9;
reg  [8:0] wlo9;
reg  [7:0] whi;
reg [15:0] wres;
reg  [7:0] wf_d;
reg  [7:0] rmw_d;
wire       start;
wire       io_ok;
wire       is_io;
wire       is_word;
wire [7:0] mem_a;
wire [7:0] mem_b;
wire       mem_we;
wire [4:0] mem_waddr;
wire [7:0] mem_wdata;
wire       bus_io;
wire       rmw_step;

assign start   = op_valid && !busy_q;
assign is_io   = (op_code == `ALU_OP_IOCLR) || (op_code == `ALU_OP_IOSET);
assign is_word = (op_code == `ALU_OP_WADD) || (op_code == `ALU_OP_WSUB);
assign io_ok   = (op_io_addr <= `ALU_IO_LAST);
assign bus_io  = (reg_addr <= `ALU_IO_LAST);

// ===========================================
// Byte operations
always @*
begin
	b_op = op_src;
	if ((op_code == `ALU_OP_SUBK) || (op_code == `ALU_OP_SBBK) ||
		(op_code == `ALU_OP_ANDK) || (op_code == `ALU_OP_ORK))
	begin
		b_op = op_const;
	end
	cin = 1'b0;
	if ((op_code == `ALU_OP_ADC) || (op_code == `ALU_OP_SBB) ||
		(op_code == `ALU_OP_SBBK))
	begin
		cin = sreg_q[`ALU_FLAG_C];
	end
	sum9 = {1'b0, op_dst} + {1'b0, b_op} + {8'h00, cin};
	dif9 = {1'b0, op_dst} - {1'b0, b_op} - {8'h00, cin};
	r_d = op_dst;
	f_d = sreg_q;
	case (op_code)
		`ALU_OP_ADD, `ALU_OP_ADC:
		begin
			r_d = sum9[7:0];
			f_d[`ALU_FLAG_H] = (op_dst[3] & b_op[3]) | (b_op[3] & ~r_d[3]) |
				(~r_d[3] & op_dst[3]);
			f_d[`ALU_FLAG_V] = (op_dst[7] & b_op[7] & ~r_d[7]) |
				(~op_dst[7] & ~b_op[7] & r_d[7]);
			f_d[`ALU_FLAG_C] = sum9[8];
			f_d[`ALU_FLAG_N] = r_d[7];
			f_d[`ALU_FLAG_Z] = (r_d == 8'h00);
		end
		`ALU_OP_SUB, `ALU_OP_SUBK, `ALU_OP_SBB, `ALU_OP_SBBK:
		begin
			r_d = dif9[7:0];
			f_d[`ALU_FLAG_H] = (~op_dst[3] & b_op[3]) | (b_op[3] & r_d[3]) |
				(r_d[3] & ~op_dst[3]);
			f_d[`ALU_FLAG_V] = (op_dst[7] & ~b_op[7] & ~r_d[7]) |
				(~op_dst[7] & b_op[7] & r_d[7]);
			f_d[`ALU_FLAG_C] = dif9[8];
			f_d[`ALU_FLAG_N] = r_d[7];
			f_d[`ALU_FLAG_Z] = (r_d == 8'h00);
		end
		`ALU_OP_AND, `ALU_OP_ANDK, `ALU_OP_TEST:
		begin
			r_d = op_dst & b_op;
			if (op_code == `ALU_OP_TEST)
			begin
				r_d = op_dst;
			end
			f_d[`ALU_FLAG_V] = 1'b0;
			f_d[`ALU_FLAG_N] = r_d[7];
			f_d[`ALU_FLAG_Z] = (r_d == 8'h00);
		end
		`ALU_OP_OR, `ALU_OP_ORK:
		begin
			r_d = op_dst | b_op;
			f_d[`ALU_FLAG_V] = 1'b0;
			f_d[`ALU_FLAG_N] = r_d[7];
			f_d[`ALU_FLAG_Z] = (r_d == 8'h00);
		end
		default:
		begin
			r_d = op_dst;
		end
	endcase
end

// ===========================================
// Word operations, low byte on the first clock, high byte on the second
always @*
begin
	if (op_code == `ALU_OP_WADD)
	begin
		wlo9 = {1'b0, op_dst} + {1'b0, op_const};
	end
	else
	begin
		wlo9 = {1'b0, op_dst} - {1'b0, op_const};
	end
	if (op_q == `ALU_OP_WADD)
	begin
		whi = hi_q + {7'h00, cy_q};
	end
	else
	begin
		whi = hi_q - {7'h00, cy_q};
	end
	wres = {whi, lo_q};
	wf_d = sreg_q;
	wf_d[`ALU_FLAG_N] = wres[15];
	wf_d[`ALU_FLAG_Z] = (wres == 16'h0000);
	if (op_q == `ALU_OP_WADD)
	begin
		wf_d[`ALU_FLAG_V] = ~hi_q[7] & wres[15];
		wf_d[`ALU_FLAG_C] = ~wres[15] & hi_q[7];
	end
	else
	begin
		wf_d[`ALU_FLAG_V] = hi_q[7] & ~wres[15];
		wf_d[`ALU_FLAG_C] = wres[15] & ~hi_q[7];
	end
	wf_d[`ALU_FLAG_S] = wf_d[`ALU_FLAG_N] ^ wf_d[`ALU_FLAG_V];
end

// ===========================================
// I/O read-modify-write data
always @*
begin
	rmw_d = mem_b;
	rmw_d[io_bit_q] = (op_q == `ALU_OP_IOSET);
end

assign rmw_step  = (op_q == `ALU_OP_IOCLR) || (op_q == `ALU_OP_IOSET);
assign mem_we    = (busy_q && rmw_step) || (reg_wr && bus_io);
assign mem_waddr = (busy_q && rmw_step) ? io_addr_q : reg_addr[4:0];
assign mem_wdata = (busy_q && rmw_step) ? rmw_d : reg_wdata;

alu_iomem
#(
	.AW (5),
	.DW (8)
)
u_iomem
(
	.clk       (clk),
	.nrst      (nrst),
	.we        (mem_we),
	.waddr     (mem_waddr),
	.wdata     (mem_wdata),
	.ra_addr   (reg_addr[4:0]),
	.ra_data_q (mem_a),
	.rb_addr   (op_io_addr[4:0]),
	.rb_data_q (mem_b)
);

// ===========================================
// Sequencing and results
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		busy_q      <= 1'b0;
		cnt_q       <= 2'd0;
		op_q        <= `ALU_OP_ADD;
		lo_q        <= 8'h00;
		hi_q        <= 8'h00;
		cy_q        <= 1'b0;
		io_addr_q   <= 5'h00;
		io_bit_q    <= 3'd0;
		res_valid_q <= 1'b0;
		res_lo_q    <= 8'h00;
		res_hi_q    <= 8'h00;
		res_word_q  <= 1'b0;
		op_err_q    <= 1'b0;
		sreg_q      <= `ALU_SREG_RST;
	end
	else
	begin
		res_valid_q <= 1'b0;
		op_err_q    <= 1'b0;
		if (reg_wr && (reg_addr == `ALU_SREG_ADDR))
		begin
			sreg_q <= reg_wdata;
		end
		if (busy_q)
		begin
			cnt_q <= cnt_q + 2'd1;
			if (rmw_step)
			begin
				if (cnt_q == `ALU_RMW_CLKS - 2'd1)
				begin
					busy_q      <= 1'b0;
					res_valid_q <= 1'b1;
					res_lo_q    <= rmw_d;
					res_word_q  <= 1'b0;
				end
			end
			else if (cnt_q == `ALU_WORD_CLKS - 2'd1)
			begin
				busy_q      <= 1'b0;
				res_valid_q <= 1'b1;
				res_lo_q    <= lo_q;
				res_hi_q    <= whi;
				res_word_q  <= 1'b1;
				sreg_q      <= wf_d;
			end
		end
		else if (start)
		begin
			op_q      <= op_code;
			io_addr_q <= op_io_addr[4:0];
			io_bit_q  <= op_io_bit;
			lo_q      <= wlo9[7:0];
			cy_q      <= wlo9[8];
			hi_q      <= op_hi;
			cnt_q     <= `ALU_BYTE_CLKS;
			if (is_io && !io_ok)
			begin
				op_err_q <= 1'b1;
			end
			else if (is_io || is_word)
			begin
				busy_q <= 1'b1;
			end
			else if (op_code <= `ALU_OP_TEST)
			begin
				res_valid_q <= 1'b1;
				res_lo_q    <= r_d;
				res_word_q  <= 1'b0;
				sreg_q      <= f_d;
			end
			else
			begin
				op_err_q <= 1'b1;
			end
		end
	end
end

// ===========================================
// Register port reads
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		rsel_q    <= SEL_ZERO;
		sreg_rd_q <= 8'h00;
	end
	else
	begin
		sreg_rd_q <= sreg_q;
		if (reg_rd && bus_io)
		begin
			rsel_q <= SEL_MEM;
		end
		else if (reg_rd && (reg_addr == `ALU_SREG_ADDR))
		begin
			rsel_q <= SEL_SREG;
		end
		else
		begin
			rsel_q <= SEL_ZERO;
		end
	end
end

assign reg_rdata = (rsel_q == SEL_MEM) ? mem_a :
	((rsel_q == SEL_SREG) ? sreg_rd_q : 8'h00);

endmodule

// ---- alu_regs.vh ----
// Constants of the arithmetic and logic datapath
`ifndef ALU_REGS_VH
`define ALU_REGS_VH

// ===========================================
// Operation codes
`define ALU_OP_ADD    4'h0
`define ALU_OP_ADC    4'h1
`define ALU_OP_WADD   4'h2
`define ALU_OP_SUB    4'h3
`define ALU_OP_SUBK   4'h4
`define ALU_OP_SBB    4'h5
`define ALU_OP_SBBK   4'h6
`define ALU_OP_WSUB   4'h7
`define ALU_OP_AND    4'h8
`define ALU_OP_ANDK   4'h9
`define ALU_OP_OR     4'ha
`define ALU_OP_ORK    4'hb
`define ALU_OP_TEST   4'hc
`define ALU_OP_IOCLR  4'hd
`define ALU_OP_IOSET  4'he

// ===========================================
// Status register bit positions
`define ALU_FLAG_C    0
`define ALU_FLAG_Z    1
`define ALU_FLAG_N    2
`define ALU_FLAG_V    3
`define ALU_FLAG_S    4
`define ALU_FLAG_H    5

// ===========================================
// Register port map and reset values
`define ALU_IO_FIRST  6'h00
`define ALU_IO_LAST   6'h1f
`define ALU_SREG_ADDR 6'h3f
`define ALU_SREG_RST  8'h00

// ===========================================
// Operation lengths in clocks
`define ALU_BYTE_CLKS 2'd1
`define ALU_WORD_CLKS 2'd2
`define ALU_RMW_CLKS  2'd2

`endif

// ---- alu_iomem.v ----
// Low I/O register space memory with two registered read ports
`timescale 1ns/100ps
module alu_iomem
#(
	parameter AW = 5,
	parameter DW = 8
)
(
	// Clock and reset
	input  wire          clk,
	input  wire          nrst,
	// Write port
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	// Read ports
	input  wire [AW-1:0] ra_addr,
	output reg  [DW-1:0] ra_data_q,
	input  wire [AW-1:0] rb_addr,
	output reg  [DW-1:0] rb_data_q
);

reg [DW-1:0] mem [0:(1<<AW)-1];

// ===========================================
// Storage
always @(posedge clk)
begin
	if (we)
	begin
		mem[waddr] <= wdata;
	end
end

// ===========================================
// Registered reads
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		ra_data_q <= {DW{1'b0}};
		rb_data_q <= {DW{1'b0}};
	end
	else
	begin
		ra_data_q <= mem[ra_addr];
		rb_data_q <= mem[rb_addr];
	end
end

endmodule

// ---- alu_datapath_sva.sv ----
// Checker of datapath timing and flags
`timescale 1ns/100ps
module alu_datapath_chk
(
	// Datapath ports
	input wire       clk,
	input wire       nrst,
	input wire       op_valid,
	input wire [3:0] op_code,
	input wire [7:0] op_dst,
	input wire [5:0] op_io_addr,
	input wire       res_valid_q,
	input wire [7:0] res_lo_q,
	input wire       res_word_q,
	input wire       op_err_q,
	input wire       busy_q,
	input wire [7:0] sreg_q
);
	wire acc = op_valid & ~busy_q;
	wire ari = op_code < 4'h2 || (op_code > 4'h2 && op_code < 4'h7);
	wire lgc = op_code > 4'h7 && op_code < 4'hd;
	wire wrd = op_code == 4'h2 || op_code == 4'h7;
	wire iob = op_code == 4'hd || op_code == 4'he;
	// =====
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_byte_lat: assert property
		(acc && (ari || lgc) |=> res_valid_q && !busy_q) else $error("late");
	chk_word_lat: assert property
		(acc && wrd |=> busy_q ##1 res_valid_q && res_word_q) else $error("wlat");
	chk_io_range: assert property
		(acc && iob && op_io_addr > 6'h1f |=> op_err_q && !busy_q)
		else $error("range");
	chk_logic_flags: assert property
		(acc && lgc |=> !sreg_q[3] && (sreg_q & 8'hf1) == ($past(sreg_q) & 8'hf1))
		else $error("lflag");
	chk_arith_keep: assert property
		(acc && ari |=> (sreg_q & 8'hd0) == ($past(sreg_q) & 8'hd0))
		else $error("akeep");
	chk_word_keep: assert property
		(acc && wrd |-> ##2 (sreg_q & 8'he0) == ($past(sreg_q, 2) & 8'he0))
		else $error("wkeep");
	chk_word_sign: assert property
		(res_valid_q && res_word_q |-> sreg_q[4] == (sreg_q[2] ^ sreg_q[3]))
		else $error("sign");
	chk_test_keep: assert property
		(acc && op_code == 4'hc |=> res_lo_q == $past(op_dst)
		&& sreg_q[1] == ($past(op_dst) == 8'h00)) else $error("test");
	cover property (acc && wrd);
	cover property (op_err_q);
	cover property (acc && op_code == 4'hc);
endmodule
bind alu_datapath alu_datapath_chk u_chk (.*);

// ---- cpu_arith_logic_datapath_bench.sv ----
// Self-checking bench of the datapath
`timescale 1ns/100ps
module cpu_arith_logic_datapath_bench;
	logic       clk = 0, nrst = 0, op_valid = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] op_code = 0;
	logic [7:0] op_dst = 0, op_hi = 0, op_src = 0, op_const = 0;
	logic [7:0] reg_wdata = 0, sr = 0;
	logic [5:0] op_io_addr = 0, reg_addr = 0;
	logic [2:0] op_io_bit = 0;
	logic [31:0] rs = 4950, v;
	wire        res_valid_q, res_word_q, op_err_q, busy_q;
	wire  [7:0] res_lo_q, res_hi_q, sreg_q, reg_rdata;
	int         err_count = 0, total_checks = 0, cyc = 0, i, c;
	alu_datapath DUT (.clk(clk), .nrst(nrst), .op_valid(op_valid),
		.op_code(op_code), .op_dst(op_dst), .op_hi(op_hi), .op_src(op_src),
		.op_const(op_const), .op_io_addr(op_io_addr), .op_io_bit(op_io_bit),
		.res_valid_q(res_valid_q), .res_lo_q(res_lo_q), .res_hi_q(res_hi_q),
		.res_word_q(res_word_q), .op_err_q(op_err_q), .busy_q(busy_q),
		.sreg_q(sreg_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			err_count++;
			summarize();
		end
	end
	// =====
	// Helpers
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task chk(input logic [15:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task summarize();
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wr(input [5:0] a, input [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input [5:0] a, input [7:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	task op(input [3:0] k, input [7:0] d, h, s, q);
		int n;
		@(posedge clk);
		op_valid <= 1;
		op_code <= k;
		op_dst <= d;
		op_hi <= h;
		op_src <= s;
		op_const <= q;
		@(posedge clk);
		op_valid <= 0;
		#1 n = 0;
		while (res_valid_q !== 1'b1 && op_err_q !== 1'b1 && n < 4)
		begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	// Model of one operation
	task alu(input [3:0] k, input [7:0] d, h, s, q);
		int r, w, b, ci, lg, wd, sb, ms, ws, dd;
		logic [15:0] m;
		dd = d;
		wd = k == 2 || k == 7;
		sb = k > 2 && k < 8;
		lg = k > 7;
		b = (k inside {0, 1, 3, 5, 8, 10}) ? s : q;
		ci = (k == 1 || k == 5 || k == 6) ? sr[0] : 0;
		w = wd ? {h, d} : d;
		r = sb ? w - b - ci : w + b + ci;
		if (lg)
			r = k < 10 ? d & b : k == 12 ? d : d | b;
		m = r[15:0];
		ms = wd ? m[15] : m[7];
		ws = wd ? w[15] : w[7];
		sr[1] = wd ? m == 0 : m[7:0] == 0;
		sr[2] = ms;
		sr[3] = !lg && (sb ? ws != (wd ? 0 : b[7]) : ws == (wd ? 0 : b[7]))
			&& ms != ws;
		if (!lg)
			sr[0] = sb ? r < 0 : r > (wd ? 65535 : 255);
		if (wd)
			sr[4] = sr[2] ^ sr[3];
		else if (!lg)
			sr[5] = sb ? dd % 16 - b % 16 - ci < 0 : dd % 16 + b % 16 + ci > 15;
		op(k, d, h, s, q);
		chk(res_valid_q, 1);
		chk({wd ? res_hi_q : 8'h00, res_lo_q}, wd ? m : m & 16'hff);
		chk(sreg_q, sr);
		chk(res_word_q, wd);
	endtask
	task bitop(input [3:0] k, input [5:0] a, input [2:0] n, input [7:0] d);
		logic [7:0] e;
		e = k == 4'he ? d | (8'h01 << n) : d & ~(8'h01 << n);
		if (a <= 6'h1f)
			wr(a, d);
		op_io_addr <= a;
		op_io_bit <= n;
		op(k, 0, 0, 0, 0);
		chk(res_valid_q, a <= 6'h1f);
		if (a > 6'h1f)
		begin
			chk(op_err_q, 1);
			e = 0;
		end
		else
			chk(res_lo_q, e);
		chk(sreg_q, sr);
		rd(a, e);
	endtask
	// =====
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		rd(6'h3f, 8'h00);
		$display("reset test done");
		repeat (30)
		begin
			v = rnd();
			sr = v[7:0] & 8'h3f;
			wr(6'h3f, sr);
			for (c = 0; c < 13; c++)
			begin
				v = rnd();
				alu(c, v[7:0], v[15:8], v[23:16], v[31:24]);
			end
			rd(6'h3f, sr);
		end
		alu(2, 8'hff, 8'h7f, 0, 1);
		alu(2, 8'hff, 8'hff, 0, 8'hff);
		alu(7, 8'h00, 8'h80, 0, 1);
		alu(7, 8'h05, 8'h00, 0, 5);
		$display("operation test done");
		op(4'hf, 0, 0, 0, 0);
		chk(op_err_q, 1);
		chk(sreg_q, sr);
		for (i = 0; i < 6; i++)
		begin
			v = rnd();
			bitop(i % 2 ? 4'hd : 4'he, i < 2 ? 6'h00 : i < 4 ? 6'h1f : 6'h1c + i,
				v[2:0], v[15:8]);
		end
		rd(6'h3e, 8'h00);
		$display("bit access test done");
		summarize();
	end
endmodule
